// file: hw/sbfc_bridge.sv
// serial bridge with hardware flow control, registers on apb
//
// Contract
// - reset gives 115200 baud, 8N1, both handshake directions off.
// - divisor accepts 9600 to 921600 baud; each handshake line enabled alone.
// - with output handshake on, deassert clear-to-send while receive buffer full.
// - with input handshake on, start no byte while request-to-send deasserted.
// - a byte already started always completes; target takes one more.
// - disabled mode: clear-to-send undriven, request-to-send ignored, send freely.
// - output-only mode: drive clear-to-send from buffer level, ignore request-to-send.
// - input-only mode: clear-to-send undriven, send only while request-to-send asserted.
// - full mode: drive clear-to-send and gate sending on request-to-send.
// - every target byte goes to active host, every host byte to target; code drops target bytes when full, host writes when a byte pends.
// - one host channel at a time; open network blocks usb both ways.
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
module sbfc_bridge
  import sbfc_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // target link
  input  wire logic        link_enable,
  input  wire logic        tgt_txd,
  output logic             tgt_rxd,
  input  wire logic        tgt_rts_n,
  output logic             tgt_cts_n,
  output logic             tgt_cts_oe
);
  `include "sbfc_regs.svh"

  localparam int DEPTH = `SBFC_RXQ_DEPTH;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  sbfc_ctrl_s  ctrl_reg, ctrl_next;
  logic [15:0] div_reg, div_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;
  logic [7:0]  q_mem [DEPTH];
  logic [4:0]  wr_reg, wr_next;
  logic [4:0]  rd_reg, rd_next;
  logic        ovr_reg, ovr_next;
  logic [7:0]  txb_reg, txb_next;
  logic        txp_reg, txp_next;
  logic        cts_n_reg, cts_n_next;
  logic        cts_oe_reg, cts_oe_next;

  // ------------------------------------------------------------------
  // derived signals
  // ------------------------------------------------------------------
  sbfc_mode_e  mode;
  sbfc_byte_s  rx_byte;
  logic [4:0]  q_cnt;
  logic        q_full;
  logic        q_empty;
  logic        tx_busy;
  logic        tx_start;
  logic        rts_ok;
  logic        push;
  logic        pop;
  logic        acc_done;
  logic        wr_acc;
  logic        rd_acc;
  logic [15:0] wdiv;

  assign q_cnt    = wr_reg - rd_reg;
  assign q_full   = (q_cnt == 5'(DEPTH));
  assign q_empty  = (q_cnt == 5'h00);
  assign acc_done = psel & penable & pready_reg;
  assign wr_acc   = acc_done & pwrite & ~pslverr_reg;
  assign rd_acc   = acc_done & ~pwrite & ~pslverr_reg;
  assign wdiv     = pwdata[15:0];

  // mode decode from the two independent enables
  always_comb begin
    case ({ctrl_reg.rts_in_en, ctrl_reg.cts_out_en})
      2'b01:   mode = SBFC_HS_OUT;
      2'b10:   mode = SBFC_HS_IN;
      2'b11:   mode = SBFC_HS_FULL;
      default: mode = SBFC_HS_OFF;
    endcase
  end

  // ------------------------------------------------------------------
  // bit engines
  // ------------------------------------------------------------------
  sbfc_uart_tx u_tx (
    .pclk    (pclk),
    .presetn (presetn),
    .div     (div_reg),
    .start   (tx_start),
    .data    (txb_reg),
    .busy    (tx_busy),
    .txd     (tgt_rxd)
  );

  sbfc_uart_rx u_rx (
    .pclk    (pclk),
    .presetn (presetn),
    .div     (div_reg),
    .rxd     (tgt_txd),
    .rx_byte (rx_byte)
  );

  // ------------------------------------------------------------------
  // transmit gating toward the target
  // ------------------------------------------------------------------
  // request-to-send is only looked at when a new frame would start, so a
  // late deassertion never cuts a frame in half
  always_comb begin
    case (mode)
      SBFC_HS_IN, SBFC_HS_FULL: rts_ok = ~tgt_rts_n;
      default:                  rts_ok = 1'b1;
    endcase
  end

  assign tx_start = txp_reg & ~tx_busy & link_enable & rts_ok;

  // ------------------------------------------------------------------
  // receive buffer from the target
  // ------------------------------------------------------------------
  // a byte arriving while full is dropped and flagged; with output
  // handshake on this needs a target that ignores clear-to-send
  assign push = rx_byte.valid & link_enable & ~q_full;
  assign pop  = rd_acc & ~q_empty
              & (((paddr == `SBFC_OFS_USB_RX) & ~ctrl_reg.net_open)
              |  ((paddr == `SBFC_OFS_NET_RX) &  ctrl_reg.net_open));

  always_comb begin
    wr_next  = push ? wr_reg + 5'h01 : wr_reg;
    rd_next  = pop  ? rd_reg + 5'h01 : rd_reg;
    ovr_next = ovr_reg;
    if (wr_acc && paddr == `SBFC_OFS_STATUS && pwdata[`SBFC_ST_OVR]) begin
      ovr_next = 1'b0;
    end
    if (rx_byte.valid && link_enable && q_full) begin
      ovr_next = 1'b1;                                 // set wins over clear
    end
  end

  // storage only; pointers reset elsewhere
  always_ff @(posedge pclk) begin
    if (push) begin
      q_mem[wr_reg[3:0]] <= rx_byte.data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_reg  <= 5'h00;
      rd_reg  <= 5'h00;
      ovr_reg <= 1'b0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      ovr_reg <= ovr_next;
    end
  end

  // ------------------------------------------------------------------
  // clear-to-send toward the target
  // ------------------------------------------------------------------
  always_comb begin
    case (mode)
      SBFC_HS_OUT, SBFC_HS_FULL: begin
        cts_oe_next = 1'b1;
        cts_n_next  = q_full;
      end
      default: begin
        cts_oe_next = 1'b0;
        cts_n_next  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cts_oe_reg <= 1'b0;
      cts_n_reg  <= 1'b1;
    end else begin
      cts_oe_reg <= cts_oe_next;
      cts_n_reg  <= cts_n_next;
    end
  end

  // ------------------------------------------------------------------
  // host transmit holding byte
  // ------------------------------------------------------------------
  always_comb begin
    txb_next = txb_reg;
    txp_next = txp_reg & ~tx_start;
    if (wr_acc && !txp_reg &&
        (((paddr == `SBFC_OFS_USB_TX) && !ctrl_reg.net_open) ||
         ((paddr == `SBFC_OFS_NET_TX) &&  ctrl_reg.net_open))) begin
      txb_next = pwdata[7:0];
      txp_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txb_reg <= 8'h00;
      txp_reg <= 1'b0;
    end else begin
      txb_reg <= txb_next;
      txp_reg <= txp_next;
    end
  end

  // ------------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------------
  // divisor writes outside the supported baud range are ignored
  always_comb begin
    ctrl_next = ctrl_reg;
    div_next  = div_reg;
    if (wr_acc && paddr == `SBFC_OFS_CTRL) begin
      ctrl_next.cts_out_en = pwdata[`SBFC_CTRL_CTS_OUT];
      ctrl_next.rts_in_en  = pwdata[`SBFC_CTRL_RTS_IN];
      ctrl_next.net_open   = pwdata[`SBFC_CTRL_NET];
    end
    if (wr_acc && paddr == `SBFC_OFS_DIV &&
        wdiv >= 16'(`SBFC_DIV_MIN) && wdiv <= 16'(`SBFC_DIV_MAX)) begin
      div_next = wdiv;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `SBFC_CTRL_RST;
      div_reg  <= 16'(`SBFC_DIV_DEF);
    end else begin
      ctrl_reg <= ctrl_next;
      div_reg  <= div_next;
    end
  end

  // ------------------------------------------------------------------
  // apb answer: one wait state, data and error latched in the first
  // access cycle so they stand while pready is high
  // ------------------------------------------------------------------
  always_comb begin
    pready_next  = psel & penable & ~pready_reg;
    prdata_next  = prdata_reg;
    pslverr_next = pslverr_reg;
    if (psel && penable && !pready_reg) begin
      prdata_next  = 32'h0000_0000;
      pslverr_next = 1'b0;
      case (paddr)
        `SBFC_OFS_CTRL: prdata_next[2:0] = ctrl_reg;
        `SBFC_OFS_DIV:  prdata_next[15:0] = div_reg;
        `SBFC_OFS_STATUS: begin
          prdata_next[4:0]              = q_cnt;
          prdata_next[`SBFC_ST_FULL]    = q_full;
          prdata_next[`SBFC_ST_TXBUSY]  = tx_busy;
          prdata_next[`SBFC_ST_TXPEND]  = txp_reg;
          prdata_next[`SBFC_ST_OVR]     = ovr_reg;
          prdata_next[`SBFC_ST_LINK]    = link_enable;
        end
        `SBFC_OFS_USB_TX: pslverr_next = ctrl_reg.net_open | ~pwrite;
        `SBFC_OFS_NET_TX: pslverr_next = ~ctrl_reg.net_open | ~pwrite;
        `SBFC_OFS_USB_RX: begin
          pslverr_next = ctrl_reg.net_open | pwrite;
          prdata_next[`SBFC_RX_VALID] = ~q_empty;
          prdata_next[7:0]            = q_mem[rd_reg[3:0]];
        end
        `SBFC_OFS_NET_RX: begin
          pslverr_next = ~ctrl_reg.net_open | pwrite;
          prdata_next[`SBFC_RX_VALID] = ~q_empty;
          prdata_next[7:0]            = q_mem[rd_reg[3:0]];
        end
        default: pslverr_next = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= pready_next;
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign tgt_cts_n  = cts_n_reg;
  assign tgt_cts_oe = cts_oe_reg;
endmodule

// file: hw/sbfc_regs.svh
// register offsets, field positions, reset values and timing counts of the serial bridge
`ifndef SBFC_REGS_SVH
`define SBFC_REGS_SVH

// ------------------------------------------------------------------
// clock and bit timing
// ------------------------------------------------------------------
`define SBFC_CLK_HZ        100000000
`define SBFC_BAUD_DEF      115200
`define SBFC_BAUD_MIN      9600
`define SBFC_BAUD_MAX      921600
`define SBFC_DIV_DEF       (`SBFC_CLK_HZ / `SBFC_BAUD_DEF)
`define SBFC_DIV_MAX       (`SBFC_CLK_HZ / `SBFC_BAUD_MIN)
`define SBFC_DIV_MIN       (`SBFC_CLK_HZ / `SBFC_BAUD_MAX)

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define SBFC_OFS_CTRL      8'h00
`define SBFC_OFS_DIV       8'h04
`define SBFC_OFS_STATUS    8'h08
`define SBFC_OFS_USB_TX    8'h0C
`define SBFC_OFS_USB_RX    8'h10
`define SBFC_OFS_NET_TX    8'h14
`define SBFC_OFS_NET_RX    8'h18

// ------------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------------
`define SBFC_CTRL_CTS_OUT  0
`define SBFC_CTRL_RTS_IN   1
`define SBFC_CTRL_NET      2
`define SBFC_CTRL_RST      3'h0
`define SBFC_ST_FULL       5
`define SBFC_ST_TXBUSY     6
`define SBFC_ST_TXPEND     7
`define SBFC_ST_OVR        8
`define SBFC_ST_LINK       9
`define SBFC_RX_VALID      8
`define SBFC_RXQ_DEPTH     16

`endif

// file: hw/sbfc_pkg.sv
// types shared by the serial bridge modules
package sbfc_pkg;

  // handshake mode, derived from the two enable bits
  typedef enum logic [3:0] {
    SBFC_HS_OFF  = 4'h1,
    SBFC_HS_OUT  = 4'h2,
    SBFC_HS_IN   = 4'h4,
    SBFC_HS_FULL = 4'h8
  } sbfc_mode_e;

  // bit engine states, shared by transmitter and receiver
  typedef enum logic [3:0] {
    SBFC_BIT_IDLE  = 4'h1,
    SBFC_BIT_START = 4'h2,
    SBFC_BIT_DATA  = 4'h4,
    SBFC_BIT_STOP  = 4'h8
  } sbfc_bit_e;

  // software control word
  typedef struct packed {
    logic net_open;
    logic rts_in_en;
    logic cts_out_en;
  } sbfc_ctrl_s;

  // received byte handed to the buffer
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } sbfc_byte_s;

endpackage

// file: hw/sbfc_uart_tx.sv
// 8N1 transmitter toward the target
`timescale 1ns/1ps
module sbfc_uart_tx
  import sbfc_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // control
  input  wire logic [15:0] div,
  input  wire logic        start,
  input  wire logic [7:0]  data,
  // status and line
  output logic             busy,
  output logic             txd
);
  sbfc_bit_e   st_reg, st_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [2:0]  bit_reg, bit_next;
  logic [7:0]  sh_reg, sh_next;
  logic        txd_reg, txd_next;

  assign busy = (st_reg != SBFC_BIT_IDLE);
  assign txd  = txd_reg;

  // start low, eight bits lsb first, stop high
  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    sh_next  = sh_reg;
    txd_next = txd_reg;
    case (st_reg)
      SBFC_BIT_IDLE: begin
        txd_next = 1'b1;
        if (start) begin
          sh_next  = data;
          cnt_next = div - 16'h0001;
          txd_next = 1'b0;
          st_next  = SBFC_BIT_START;
        end
      end
      SBFC_BIT_START, SBFC_BIT_DATA: begin
        if (cnt_reg != 16'h0000) begin
          cnt_next = cnt_reg - 16'h0001;
        end else begin
          cnt_next = div - 16'h0001;
          if (st_reg == SBFC_BIT_START) begin
            bit_next = 3'h0;
            st_next  = SBFC_BIT_DATA;
            txd_next = sh_reg[0];
            sh_next  = {1'b0, sh_reg[7:1]};
          end else if (bit_reg == 3'h7) begin
            st_next  = SBFC_BIT_STOP;
            txd_next = 1'b1;
          end else begin
            bit_next = bit_reg + 3'h1;
            txd_next = sh_reg[0];
            sh_next  = {1'b0, sh_reg[7:1]};
          end
        end
      end
      SBFC_BIT_STOP: begin
        if (cnt_reg != 16'h0000) begin
          cnt_next = cnt_reg - 16'h0001;
        end else begin
          st_next = SBFC_BIT_IDLE;
        end
      end
      default: st_next = SBFC_BIT_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg  <= SBFC_BIT_IDLE;
      cnt_reg <= 16'h0000;
      bit_reg <= 3'h0;
      sh_reg  <= 8'h00;
      txd_reg <= 1'b1;
    end else begin
      st_reg  <= st_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      sh_reg  <= sh_next;
      txd_reg <= txd_next;
    end
  end
endmodule

// file: hw/sbfc_uart_rx.sv
// 8N1 receiver from the target
`timescale 1ns/1ps
module sbfc_uart_rx
  import sbfc_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // control and line
  input  wire logic [15:0] div,
  input  wire logic        rxd,
  // received byte, valid for one cycle
  output sbfc_pkg::sbfc_byte_s rx_byte
);
  sbfc_bit_e   st_reg, st_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [2:0]  bit_reg, bit_next;
  logic [7:0]  sh_reg, sh_next;
  sbfc_byte_s  out_reg, out_next;

  assign rx_byte = out_reg;

  // sample at mid bit; a bad stop bit drops the byte
  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    sh_next  = sh_reg;
    out_next = '{valid: 1'b0, data: out_reg.data};
    case (st_reg)
      SBFC_BIT_IDLE: begin
        if (!rxd) begin
          cnt_next = {1'b0, div[15:1]};
          st_next  = SBFC_BIT_START;
        end
      end
      SBFC_BIT_START: begin
        if (cnt_reg != 16'h0000) begin
          cnt_next = cnt_reg - 16'h0001;
        end else if (rxd) begin
          st_next = SBFC_BIT_IDLE;            // glitch, not a start bit
        end else begin
          cnt_next = div - 16'h0001;
          bit_next = 3'h0;
          st_next  = SBFC_BIT_DATA;
        end
      end
      SBFC_BIT_DATA: begin
        if (cnt_reg != 16'h0000) begin
          cnt_next = cnt_reg - 16'h0001;
        end else begin
          cnt_next = div - 16'h0001;
          sh_next  = {rxd, sh_reg[7:1]};
          bit_next = bit_reg + 3'h1;
          if (bit_reg == 3'h7) begin
            st_next = SBFC_BIT_STOP;
          end
        end
      end
      SBFC_BIT_STOP: begin
        if (cnt_reg != 16'h0000) begin
          cnt_next = cnt_reg - 16'h0001;
        end else begin
          out_next = '{valid: rxd, data: sh_reg};
          st_next  = SBFC_BIT_IDLE;
        end
      end
      default: st_next = SBFC_BIT_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg  <= SBFC_BIT_IDLE;
      cnt_reg <= 16'h0000;
      bit_reg <= 3'h0;
      sh_reg  <= 8'h00;
      out_reg <= '0;
    end else begin
      st_reg  <= st_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      sh_reg  <= sh_next;
      out_reg <= out_next;
    end
  end
endmodule

// file: testbench/sbfc_bridge_sva.sv
// assertion checker for the serial bridge ports
`timescale 1ns/1ps
`include "sbfc_regs.svh"
module sbfc_bridge_chk
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // target link
  input wire logic        link_enable,
  input wire logic        tgt_txd,
  input wire logic        tgt_rxd,
  input wire logic        tgt_rts_n,
  input wire logic        tgt_cts_n,
  input wire logic        tgt_cts_oe
);
  logic [2:0]  ctrl_reg, ctrl_next;
  logic [15:0] div_reg, div_next;
  logic [19:0] cnt_reg, cnt_next;
  logic        rxd_reg, wr_ok, start_seen;

  // ------------------------------------------------------------
  // shadow of ctrl and divisor, plus a frame timer on the tx line
  // ------------------------------------------------------------
  // the timer lets the frame checks follow any legal divisor
  always_comb begin
    wr_ok      = psel && penable && pready && pwrite && !pslverr;
    ctrl_next  = (wr_ok && paddr == `SBFC_OFS_CTRL) ? pwdata[2:0] : ctrl_reg;
    div_next   = div_reg;
    if (wr_ok && paddr == `SBFC_OFS_DIV && pwdata[15:0] >= `SBFC_DIV_MIN
        && pwdata[15:0] <= `SBFC_DIV_MAX) begin
      div_next = pwdata[15:0];
    end
    start_seen = (cnt_reg == 20'h0) && rxd_reg && !tgt_rxd;
    cnt_next   = start_seen ? 20'(div_reg) * 20'hA - 20'h1 : cnt_reg - 20'(cnt_reg != 20'h0);
  end

  // register the shadow state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= 3'h0;
      div_reg  <= 16'h364;
      cnt_reg  <= 20'h0;
      rxd_reg  <= 1'b1;
    end else begin
      ctrl_reg <= ctrl_next;
      div_reg  <= div_next;
      cnt_reg  <= cnt_next;
      rxd_reg  <= tgt_rxd;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  apb_wait_a: assert property (psel && !penable |=> penable && !pready ##1 pready)
    else $error("apb answer not after one wait state");
  ready_once_a: assert property (pready |=> !pready)
    else $error("pready held over one cycle");
  reset_out_a: assert property ($rose(presetn) |-> tgt_rxd && !tgt_cts_oe && !pready)
    else $error("outputs not idle after reset");
  rts_gate_a: assert property (start_seen && ctrl_reg[1] |-> !$past(tgt_rts_n))
    else $error("frame started while request-to-send deasserted");
  link_gate_a: assert property (start_seen |-> $past(link_enable))
    else $error("frame started while link disabled");
  start_low_a: assert property (cnt_reg > 20'(div_reg) * 20'h9 |-> !tgt_rxd)
    else $error("start bit not low for a full bit");
  stop_high_a: assert property (cnt_reg != 20'h0 && cnt_reg <= 20'(div_reg) |-> tgt_rxd)
    else $error("stop bit not high");
  cts_oe_a: assert property (ctrl_reg[0] == $past(ctrl_reg[0]) |-> tgt_cts_oe == ctrl_reg[0])
    else $error("clear-to-send drive does not follow mode");
  net_block_a: assert property (psel && penable && pready && ctrl_reg[2]
    && (paddr == `SBFC_OFS_USB_TX || paddr == `SBFC_OFS_USB_RX) |-> pslverr)
    else $error("usb access allowed while network open");

  frame_c: cover property (start_seen);
  error_c: cover property (pready && pslverr);
  halt_c: cover property (tgt_cts_oe && tgt_cts_n);
endmodule

bind sbfc_bridge sbfc_bridge_chk i_sbfc_bridge_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_enable(link_enable),
  .tgt_txd(tgt_txd), .tgt_rxd(tgt_rxd), .tgt_rts_n(tgt_rts_n), .tgt_cts_n(tgt_cts_n),
  .tgt_cts_oe(tgt_cts_oe));

// file: testbench/sbfc_target_model.sv
// behavioural target uart with hardware flow control
`timescale 1ns/1ps
module sbfc_target_model #(
  parameter int DIV = 108
) (
  // clock
  input  wire logic pclk,
  // bench controls
  input  wire logic want_rx,
  input  wire logic link_on,
  // uart lines
  input  wire logic tgt_rxd,
  input  wire logic tgt_cts_n,
  input  wire logic tgt_cts_oe,
  output logic      tgt_txd,
  output logic      tgt_rts_n,
  output logic      link_enable
);
  logic [7:0] rxq[$];
  int         bad;

  // request-to-send is active low and follows readiness
  assign tgt_rts_n   = !want_rx;
  assign link_enable = link_on;

  // frame receiver: samples mid bit, counts framing faults
  initial begin : rx_loop
    logic [7:0] b;
    bad     = 0;
    tgt_txd = 1'b1;
    forever begin
      @(negedge tgt_rxd);
      repeat (DIV / 2) @(posedge pclk);
      if (tgt_rxd !== 1'b0) bad++;
      for (int i = 0; i < 8; i++) begin
        repeat (DIV) @(posedge pclk);
        b[i] = tgt_rxd;
      end
      repeat (DIV) @(posedge pclk);
      if (tgt_rxd !== 1'b1) bad++;
      rxq.push_back(b);
    end
  end

  // send one frame; holds off between frames while clear-to-send is deasserted
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    while (tgt_cts_oe && tgt_cts_n) @(posedge pclk);
    for (int i = 0; i < 10; i++) begin
      tgt_txd <= f[i];
      repeat (DIV) @(posedge pclk);
    end
  endtask
endmodule

// file: testbench/testbench.sv
// self-checking bench for the serial bridge
`timescale 1ns/1ps
`include "sbfc_regs.svh"
module testbench;
  import sbfc_pkg::*;
  localparam int DIV = 108;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        link_enable, tgt_txd, tgt_rxd, tgt_rts_n, tgt_cts_n, tgt_cts_oe;
  logic        want_rx, link_on;
  int          mismatches, n_compared;

  sbfc_bridge i_sbfc_bridge (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_enable(link_enable), .tgt_txd(tgt_txd), .tgt_rxd(tgt_rxd),
    .tgt_rts_n(tgt_rts_n), .tgt_cts_n(tgt_cts_n), .tgt_cts_oe(tgt_cts_oe));
  sbfc_target_model #(.DIV(DIV)) i_sbfc_target_model (.pclk(pclk), .want_rx(want_rx),
    .link_on(link_on), .tgt_rxd(tgt_rxd), .tgt_cts_n(tgt_cts_n), .tgt_cts_oe(tgt_cts_oe),
    .tgt_txd(tgt_txd), .tgt_rts_n(tgt_rts_n), .link_enable(link_enable));

  // ------------------------------------------------------------
  // clock, tasks
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer, entered just after a rising edge; leaves an idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("apb wait edges", 2, n);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic expect_tx(input logic [7:0] b);
    for (int k = 0; k < 3000 && i_sbfc_target_model.rxq.size() == 0; k++) @(posedge pclk);
    chk("bytes at target", 1, i_sbfc_target_model.rxq.size());
    if (i_sbfc_target_model.rxq.size() > 0) begin
      chk("byte at target", b, i_sbfc_target_model.rxq.pop_front());
    end
  endtask

  // a byte must stay held back for two frame times
  task automatic expect_held();
    repeat (2500) @(posedge pclk);
    chk("held bytes", 0, i_sbfc_target_model.rxq.size());
    apb(0, `SBFC_OFS_STATUS, 0);
    chk("pending", 1, rd[`SBFC_ST_TXPEND]);
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog: the sequence needs about 33000 cycles
  initial begin
    repeat (90000) @(posedge pclk);
    mismatches++;
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {want_rx, link_on} = 2'h3;
    mismatches = 0;
    n_compared = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("line idle", 1, tgt_rxd);
    apb(0, `SBFC_OFS_CTRL, 0);
    chk("ctrl reset", 0, rd);
    apb(0, `SBFC_OFS_DIV, 0);
    chk("div reset", `SBFC_DIV_DEF, rd);
    $display("test reset done");
    apb(1, `SBFC_OFS_DIV, `SBFC_DIV_MAX);
    apb(1, `SBFC_OFS_DIV, `SBFC_DIV_MIN - 1);
    apb(0, `SBFC_OFS_DIV, 0);
    chk("div slowest", `SBFC_DIV_MAX, rd);
    apb(1, `SBFC_OFS_DIV, DIV);
    apb(0, 8'h1C, 0);
    chk("unmapped error", 1, err);
    $display("test divisor done");
    want_rx <= 1'b0;
    apb(1, `SBFC_OFS_USB_TX, 32'hA5);
    expect_tx(8'hA5);
    chk("cts undriven", 0, tgt_cts_oe);
    i_sbfc_target_model.send(8'h3C);
    apb(0, `SBFC_OFS_USB_RX, 0);
    chk("usb rx", 32'h13C, rd);
    $display("test disabled mode done");
    apb(1, `SBFC_OFS_CTRL, 32'h2);
    want_rx <= 1'b1;
    apb(1, `SBFC_OFS_USB_TX, 32'h5A);
    for (int k = 0; k < 3000 && tgt_rxd !== 1'b0; k++) @(posedge pclk);
    want_rx <= 1'b0;
    expect_tx(8'h5A);
    apb(1, `SBFC_OFS_USB_TX, 32'hC3);
    expect_held();
    chk("cts undriven in", 0, tgt_cts_oe);
    want_rx <= 1'b1;
    expect_tx(8'hC3);
    $display("test input mode done");
    apb(1, `SBFC_OFS_CTRL, 32'h3);
    want_rx <= 1'b0;
    apb(1, `SBFC_OFS_USB_TX, 32'h81);
    expect_held();
    chk("cts driven full", 1, tgt_cts_oe);
    want_rx <= 1'b1;
    expect_tx(8'h81);
    $display("test full mode done");
    apb(1, `SBFC_OFS_CTRL, 32'h1);
    want_rx <= 1'b0;
    for (int i = 0; i < 16; i++) i_sbfc_target_model.send(8'(8'h10 + i));
    repeat (5) @(posedge pclk);
    chk("cts halts", 1, tgt_cts_n);
    apb(1, `SBFC_OFS_USB_TX, 32'h77);
    expect_tx(8'h77);
    for (int i = 0; i < 16; i++) begin
      apb(0, `SBFC_OFS_USB_RX, 0);
      chk("drain", 32'h110 + i, rd);
      @(posedge pclk); // cts trails the count by one cycle
      chk("cts released", 0, tgt_cts_n);
    end
    apb(0, `SBFC_OFS_USB_RX, 0);
    chk("empty", 0, rd[`SBFC_RX_VALID]);
    $display("test output mode done");
    apb(1, `SBFC_OFS_CTRL, 32'h4);
    apb(1, `SBFC_OFS_USB_TX, 32'h11);
    chk("usb blocked", 1, err);
    link_on <= 1'b0;
    apb(1, `SBFC_OFS_NET_TX, 32'h42);
    expect_held();
    link_on <= 1'b1;
    expect_tx(8'h42);
    i_sbfc_target_model.send(8'h24);
    apb(0, `SBFC_OFS_USB_RX, 0);
    chk("usb rx blocked", 1, err);
    apb(0, `SBFC_OFS_NET_RX, 0);
    chk("net rx", 32'h124, rd);
    chk("frame faults", 0, i_sbfc_target_model.bad);
    $display("test network done");
    tally_and_finish();
  end
endmodule
